// ==== evq_qualifier.sv ====
`timescale 1ns/100ps
// Operation
// RL1: code 1ah in select field bits 31:25 picks wide simd integer uops.
// RL2: mask bit 15 counts every wide simd integer uop.
// RL3: each qualifying wide simd uop counts, not one per instruction.
// RL4: code 04h picks legacy fp uops, counters 8 to 11 only.
// RL5: mask bit 15 counts every legacy fp uop, each uop separately.
// RL6: legacy fp event excludes load, store and register move uops.
// RL7: code 2eh picks fp/simd load, store, move uops on ports 0 and 2.
// RL8: mask bit 3 counts port 0 store/move; bit 4 port 2 loads.
// RL9: move event ignores integer moves, includes assist flows.
// RL10: code 02h machine clear only via selectors two and three.
// RL11: machine clear counts by one chosen mask bit while pipeline clears.
// RL12: bit 0 counts clear cycles; edge mode counts occurrences.
// RL13: bit 2 counts once per memory-ordering clear.
// RL14: bit 3 counts once per self-modifying-code clear.
// RL15: fp unit events only from selectors zero and one.
// RL16: same-cycle qualifying uops are summed, none dropped.
module evq_qualifier
	import evq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] wide_simd_uops,
	input wire logic [1:0] fp_uops,
	input wire logic [1:0] fp_mem_move_uops,
	input wire logic p0_fp_store_move,
	input wire logic p2_fp_load,
	input wire logic pipe_clearing,
	input wire logic mem_order_clear,
	input wire logic self_modify_clear,
	output logic irq
);
	typedef struct packed {
		logic [NUM_SEL-1:0][31:0] sel;
		logic [NUM_CNTR-1:0] route;
		logic [NUM_CNTR-1:0] edge_mode;
		logic [NUM_CNTR-1:0] stat;
		logic [NUM_CNTR-1:0] mask;
		logic clear_d;
		logic [31:0] rdata;
	} regs_s;
	regs_s st_reg, st_next;
	logic [NUM_CNTR-1:0][CNT_W-1:0] cnt;
	logic [NUM_CNTR-1:0] wrap;
	logic [NUM_CNTR-1:0] cclr;
	logic [NUM_CNTR-1:0][2:0] inc;
	logic [NUM_SEL-1:0][2:0] sel_inc;
	logic [NUM_SEL-1:0][2:0] sel_inc_edge;
	logic wr;
	logic rd;
	logic hit;
	logic [3:0] cidx;

	function automatic logic [6:0] sel_code(input logic [31:0] r);
		sel_code = r[ESEL_LSB +: ESEL_W];
	endfunction
	function automatic logic [15:0] sel_mask(input logic [31:0] r);
		sel_mask = r[EMASK_LSB +: EMASK_W];
	endfunction
	function automatic logic mask_bit(input logic [31:0] r, input int b);
		mask_bit = r[EMASK_LSB + b];
	endfunction

	// counter word window, lo or hi bank
	function automatic logic cnt_hit(input logic [11:0] a,
		input logic [11:0] base);
		return (a & 12'hfc0) == base && a[5:2] < 4'(NUM_CNTR);
	endfunction

	// wide simd integer uops, all-bit qualified
	function automatic logic [2:0] wide_inc(input logic [31:0] r,
		input logic [1:0] ws);
		logic [2:0] n;
		n = 3'h0;
		if (sel_code(r) == SEL_WIDE_SIMD && mask_bit(r, MASK_ALL_BIT)) begin
			n = {1'b0, ws}; // [RL1] [RL2] [RL3]
		end
		return n;
	endfunction

	// pipeline reports fp uops without load/store/move ones
	function automatic logic [2:0] legacy_inc(input logic [31:0] r,
		input logic [1:0] fp);
		logic [2:0] n;
		n = 3'h0;
		if (sel_code(r) == SEL_LEGACY_FP && mask_bit(r, MASK_ALL_BIT)) begin
			n = {1'b0, fp}; // [RL4] [RL5] [RL6]
		end
		return n;
	endfunction

	// port strobes carry fp/simd moves only, assists included
	function automatic logic [2:0] move_inc(input logic [31:0] r,
		input logic p0, input logic p2);
		logic [2:0] n;
		n = 3'h0;
		if (sel_code(r) == SEL_FP_MOVE) begin // [RL7] [RL9]
			if (mask_bit(r, MASK_P0_BIT) && p0) begin
				n = n + 3'h1; // [RL8]
			end
			if (mask_bit(r, MASK_P2_BIT) && p2) begin
				n = n + 3'h1; // [RL8]
			end
		end
		return n;
	endfunction

	// fp unit events, selectors zero and one only; codes are exclusive
	function automatic logic [2:0] fp_unit_inc(input logic [31:0] r,
		input logic [1:0] ws, input logic [1:0] fp,
		input logic p0, input logic p2);
		return wide_inc(r, ws) | legacy_inc(r, fp) | move_inc(r, p0, p2);
	endfunction

	function automatic logic [2:0] clear_inc(input logic [31:0] r,
		input logic busy, input logic mo, input logic sm);
		logic [2:0] n;
		n = 3'h0;
		if (sel_code(r) == SEL_MCLEAR) begin // [RL10] [RL11]
			if (mask_bit(r, MASK_CLEAR_BIT) && busy) begin
				n = n + 3'h1; // [RL12]
			end
			if (mask_bit(r, MASK_MEMORY_ORDER_CLEAR_MASK_BIT) && mo) begin
				n = n + 3'h1; // [RL13]
			end
			if (mask_bit(r, MASK_SELF_MODIFY_CLEAR_MASK_BIT) && sm) begin
				n = n + 3'h1; // [RL14]
			end
		end
		return n;
	endfunction

	always_comb begin
		for (int s = 0; s < 2; s++) begin
			sel_inc[s] = fp_unit_inc(st_reg.sel[s], wide_simd_uops, fp_uops,
				p0_fp_store_move, p2_fp_load); // [RL15]
			sel_inc_edge[s] = sel_inc[s];
		end
		for (int s = 2; s < NUM_SEL; s++) begin
			sel_inc[s] = clear_inc(st_reg.sel[s], pipe_clearing,
				mem_order_clear, self_modify_clear); // [RL10]
			// edge mode: only the rising edge of the clear window counts
			sel_inc_edge[s] = clear_inc(st_reg.sel[s],
				pipe_clearing & ~st_reg.clear_d, mem_order_clear,
				self_modify_clear); // [RL12]
		end
	end

	// counters 8,9 <- sel0; 10,11 <- sel1; 12,13,16 <- sel2; 14,15,17 <- sel3
	function automatic int src_of(input int c);
		case (c)
			0, 1: return 0;
			2, 3: return 1;
			4, 5, 8: return 2;
			default: return 3;
		endcase
	endfunction

	always_comb begin
		for (int c = 0; c < NUM_CNTR; c++) begin
			inc[c] = 3'h0;
			if (st_reg.route[c]) begin
				inc[c] = st_reg.edge_mode[c] ? sel_inc_edge[src_of(c)] :
					sel_inc[src_of(c)]; // [RL4] [RL15] [RL16]
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CNTR; g++) begin : g_cnt
			evq_uop_counter #(.WIDTH(CNT_W)) u_cnt (
				.pclk(pclk),
				.presetn(presetn),
				.clr(cclr[g]),
				.inc(inc[g]),
				.count(cnt[g]),
				.wrap(wrap[g])
			);
		end
	endgenerate

	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;

	always_comb begin
		st_next = st_reg;
		st_next.clear_d = pipe_clearing;
		cclr = '0;
		hit = 1'b1;
		cidx = paddr[5:2];
		if (paddr == OFF_SEL0 || paddr == OFF_SEL1 || paddr == OFF_SEL2 ||
			paddr == OFF_SEL3) begin
			if (wr) st_next.sel[paddr[3:2]] = pwdata;
			st_next.rdata = st_reg.sel[paddr[3:2]];
		end else if (paddr == OFF_ROUTE) begin
			if (wr) st_next.route = pwdata[NUM_CNTR-1:0];
			st_next.rdata = {22'h0, st_reg.route};
		end else if (paddr == OFF_EDGE) begin
			if (wr) st_next.edge_mode = pwdata[NUM_CNTR-1:0];
			st_next.rdata = {22'h0, st_reg.edge_mode};
		end else if (paddr == OFF_IRQ_STAT) begin
			if (wr) st_next.stat = st_reg.stat & ~pwdata[NUM_CNTR-1:0];
			st_next.rdata = {22'h0, st_reg.stat};
		end else if (paddr == OFF_IRQ_MASK) begin
			if (wr) st_next.mask = pwdata[NUM_CNTR-1:0];
			st_next.rdata = {22'h0, st_reg.mask};
		end else if (cnt_hit(paddr, OFF_CNT_LO)) begin
			if (wr) cclr[cidx] = 1'b1;
			st_next.rdata = cnt[cidx][31:0];
		end else if (cnt_hit(paddr, OFF_CNT_HI)) begin
			st_next.rdata = {24'h0, cnt[cidx][CNT_W-1:32]};
		end else begin
			hit = 1'b0;
			st_next.rdata = 32'h0;
		end
		if (!rd) st_next.rdata = st_reg.rdata;
		// wrap set wins over a same-cycle clear
		st_next.stat = st_next.stat | wrap;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.rdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign irq = |(st_reg.stat & st_reg.mask);

	AST_WIDE: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
		(st_reg.route[0] && !st_reg.edge_mode[0] &&
		sel_code(st_reg.sel[0]) == SEL_WIDE_SIMD &&
		mask_bit(st_reg.sel[0], MASK_ALL_BIT) && !cclr[0])
		|=> cnt[0] == $past(cnt[0]) + CNT_W'($past(wide_simd_uops)))
		else $error("wide simd count mismatch");
	AST_MO: assert property (@(posedge pclk) disable iff (!presetn) // [RL13]
		(sel_code(st_reg.sel[2]) == SEL_MCLEAR &&
		sel_mask(st_reg.sel[2]) == 16'h0004 && mem_order_clear)
		|-> sel_inc[2] == 3'h1)
		else $error("memory order clear not counted once");
	AST_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
		sel_code(st_reg.sel[0]) == SEL_MCLEAR |-> sel_inc[0] == 3'h0)
		else $error("machine clear taken on fp selector");
	AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
		(wrap != '0) |=> st_reg.stat[0] | ~$past(wrap[0]))
		else $error("wrap status lost");
	AST_LEVEL: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
		(sel_code(st_reg.sel[2]) == SEL_MCLEAR &&
		sel_mask(st_reg.sel[2]) == 16'h0001 && pipe_clearing)
		|-> sel_inc[2] == 3'h1)
		else $error("clear cycle not counted");
	AST_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
		(sel_code(st_reg.sel[2]) == SEL_MCLEAR &&
		sel_mask(st_reg.sel[2]) == 16'h0001 &&
		pipe_clearing && st_reg.clear_d)
		|-> sel_inc_edge[2] == 3'h0)
		else $error("edge mode counted a held clear");
	AST_RISE: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
		(sel_code(st_reg.sel[3]) == SEL_MCLEAR &&
		sel_mask(st_reg.sel[3]) == 16'h0001 &&
		pipe_clearing && !st_reg.clear_d)
		|-> sel_inc_edge[3] == 3'h1)
		else $error("edge mode missed a clear start");
	AST_MO_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // [RL13]
		(sel_code(st_reg.sel[2]) == SEL_MCLEAR &&
		sel_mask(st_reg.sel[2]) == 16'h0004 && mem_order_clear)
		|-> sel_inc_edge[2] == 3'h1)
		else $error("memory order clear lost in edge mode");
	AST_MO3: assert property (@(posedge pclk) disable iff (!presetn) // [RL13]
		(sel_code(st_reg.sel[3]) == SEL_MCLEAR &&
		sel_mask(st_reg.sel[3]) == 16'h0004 && mem_order_clear)
		|-> sel_inc[3] == 3'h1)
		else $error("memory order clear not counted on selector three");
	AST_SM: assert property (@(posedge pclk) disable iff (!presetn) // [RL14]
		(sel_code(st_reg.sel[3]) == SEL_MCLEAR &&
		sel_mask(st_reg.sel[3]) == 16'h0008 && self_modify_clear)
		|-> sel_inc[3] == 3'h1)
		else $error("self modify clear not counted once");
	AST_FP: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
		(sel_code(st_reg.sel[1]) == SEL_LEGACY_FP &&
		mask_bit(st_reg.sel[1], MASK_ALL_BIT))
		|-> sel_inc[1] == {1'b0, fp_uops})
		else $error("legacy fp uops not all counted");
	AST_MOVE: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
		(sel_code(st_reg.sel[1]) == SEL_FP_MOVE &&
		sel_mask(st_reg.sel[1]) == 16'h0018 &&
		p0_fp_store_move && p2_fp_load)
		|-> sel_inc[1] == 3'h2)
		else $error("port moves not summed");
	AST_CLR_SEL: assert property (@(posedge pclk) disable iff (!presetn) // [RL15]
		sel_code(st_reg.sel[2]) == SEL_WIDE_SIMD |-> sel_inc[2] == 3'h0)
		else $error("fp unit event taken on retire selector");
	AST_ROUTE1: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
		sel_code(st_reg.sel[1]) == SEL_MCLEAR |-> sel_inc[1] == 3'h0)
		else $error("machine clear taken on fp selector one");
	AST_NOROUTE: assert property (@(posedge pclk) disable iff (!presetn) // [RL15]
		!st_reg.route[0] |-> inc[0] == 3'h0)
		else $error("unrouted counter incremented");
	AST_CCLR: assert property (@(posedge pclk) disable iff (!presetn)
		cclr[0] |=> cnt[0] == '0)
		else $error("counter not cleared by write");
	AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		(inc[0] == 3'h0 && !cclr[0]) |=> $stable(cnt[0]))
		else $error("idle counter moved");
	AST_RDATA: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == OFF_ROUTE)
		|=> prdata == {22'h0, $past(st_reg.route)})
		else $error("route read data wrong");
endmodule

// ==== evq_pkg.sv ====
package evq_pkg;
	localparam int ESEL_LSB = 25;
	localparam int ESEL_W = 7;
	localparam int EMASK_LSB = 9;
	localparam int EMASK_W = 16;
	localparam logic [6:0] SEL_WIDE_SIMD = 7'h1a;
	localparam logic [6:0] SEL_LEGACY_FP = 7'h04;
	localparam logic [6:0] SEL_FP_MOVE = 7'h2e;
	localparam logic [6:0] SEL_MCLEAR = 7'h02;
	localparam int MASK_ALL_BIT = 15;
	localparam int MASK_P0_BIT = 3;
	localparam int MASK_P2_BIT = 4;
	localparam int MASK_CLEAR_BIT = 0;
	localparam int MASK_MEMORY_ORDER_CLEAR_MASK_BIT = 2;
	localparam int MASK_SELF_MODIFY_CLEAR_MASK_BIT = 3;
	localparam int CNT_W = 40;
	localparam int CNTR_BASE = 8;
	localparam int NUM_CNTR = 10;
	localparam int NUM_SEL = 4;
	localparam logic [11:0] OFF_SEL0 = 12'h000;
	localparam logic [11:0] OFF_SEL1 = 12'h004;
	localparam logic [11:0] OFF_SEL2 = 12'h008;
	localparam logic [11:0] OFF_SEL3 = 12'h00c;
	localparam logic [11:0] OFF_ROUTE = 12'h010;
	localparam logic [11:0] OFF_EDGE = 12'h014;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h018;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h01c;
	localparam logic [11:0] OFF_CNT_LO = 12'h040;
	localparam logic [11:0] OFF_CNT_HI = 12'h080;
	localparam logic [31:0] SEL_RESET = 32'h0000_0000;
endpackage

// ==== evq_uop_counter.sv ====
`timescale 1ns/100ps
module evq_uop_counter
	import evq_pkg::*;
#(
	parameter int WIDTH = CNT_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic [2:0] inc,
	output logic [WIDTH-1:0] count,
	output logic wrap
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic wrap;
	} cnt_s;
	cnt_s st_reg, st_next;
	logic [WIDTH:0] sum;
	always_comb begin
		// whole-cycle total added at once
		sum = {1'b0, st_reg.cnt} + {{(WIDTH-2){1'b0}}, inc};
		st_next.cnt = sum[WIDTH-1:0];
		st_next.wrap = sum[WIDTH];
		if (clr) begin
			st_next.cnt = '0;
			st_next.wrap = 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign count = st_reg.cnt;
	assign wrap = st_reg.wrap;
endmodule

// ==== evq_pipe_model.sv ====
`timescale 1ns/100ps
module evq_pipe_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic [5:0] cmd,
	input wire logic [1:0] clr_req,
	output logic [1:0] wide_simd_uops,
	output logic [1:0] fp_uops,
	output logic [1:0] fp_mem_move_uops,
	output logic p0_fp_store_move,
	output logic p2_fp_load,
	output logic pipe_clearing,
	output logic mem_order_clear,
	output logic self_modify_clear
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{wide_simd_uops, fp_uops, p0_fp_store_move, p2_fp_load} <= '0;
			fp_mem_move_uops <= '0;
			{pipe_clearing, mem_order_clear, self_modify_clear} <= '0;
		end else begin
			// fp count already has loads, stores and moves taken out
			{wide_simd_uops, fp_uops, p0_fp_store_move, p2_fp_load} <=
				go ? cmd : '0;
			fp_mem_move_uops <= go ? {cmd[1] & cmd[0], cmd[1] ^ cmd[0]} : '0;
			// one pulse per clear of kind 1 or 2, clearing level lasts two cycles; kind 3 gives no pulse and a one-cycle level
			mem_order_clear <= go && clr_req == 2'h1;
			self_modify_clear <= go && clr_req == 2'h2;
			pipe_clearing <= (go && clr_req != 2'h0) || mem_order_clear ||
				self_modify_clear;
		end
	end
endmodule

// ==== test_fp_simd_event_qualifier.sv ====
`timescale 1ns/100ps
module test_fp_simd_event_qualifier;
	import evq_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic pready, pslverr, irq, go = 0, rd_stb = 0;
	logic [1:0] clr_req = '0, ws, fp, mv, kind;
	logic [5:0] cmd = '0;
	logic p0, p2, pc, mo, sm;
	logic [32:0] rd_val, exp_q[$];
	int miscompares = 0, n_tests = 0, cyc = 0, seed = 77811;
	int unsigned acc;
	logic [1:0] cs_sel [10] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h3, 2'h2,
		2'h0, 2'h2, 2'h2};
	logic [6:0] cs_code [10] = '{SEL_WIDE_SIMD, SEL_LEGACY_FP, SEL_FP_MOVE,
		SEL_FP_MOVE, SEL_MCLEAR, SEL_MCLEAR, SEL_WIDE_SIMD, SEL_MCLEAR,
		SEL_MCLEAR, SEL_MCLEAR};
	logic [15:0] cs_mask [10] = '{16'h8000, 16'h8000, 16'h0008, 16'h0018,
		16'h0004, 16'h0008, 16'h8000, 16'h0004, 16'h0001, 16'h0001};
	int cs_n [10] = '{0, 2, 1, 3, 4, 9, 5, 0, 8, 8};
	always #12.5 pclk = ~pclk;
	evq_qualifier DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wide_simd_uops(ws), .fp_uops(fp), .fp_mem_move_uops(mv),
		.p0_fp_store_move(p0), .p2_fp_load(p2), .pipe_clearing(pc),
		.mem_order_clear(mo), .self_modify_clear(sm), .irq(irq));
	evq_pipe_model pipe (.pclk(pclk), .presetn(presetn), .go(go),
		.cmd(cmd), .clr_req(clr_req), .wide_simd_uops(ws), .fp_uops(fp),
		.fp_mem_move_uops(mv), .p0_fp_store_move(p0), .p2_fp_load(p2),
		.pipe_clearing(pc), .mem_order_clear(mo), .self_modify_clear(sm));
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [32:0] e,
		input logic [32:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!w) begin
			exp_q.push_back(e);
			rd_val = {pslverr, prdata};
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (!w) begin
			rd_stb <= 1'b1;
			@(posedge pclk);
			rd_stb <= 1'b0;
		end
	endtask
	// read monitor and hang guard
	always @(posedge pclk) begin
		cyc++;
		if (rd_stb) begin
			cmp("apb read", exp_q.pop_front(), rd_val);
		end
		if (cyc == 5000) begin
			miscompares++;
			print_verdict;
		end
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, OFF_SEL0, '0, {1'b0, SEL_RESET});
		apb(0, OFF_IRQ_STAT, '0, '0);
		apb(0, 12'h030, '0, 33'h1_0000_0000);
		apb(1, OFF_IRQ_MASK, 32'hffff_ffff, '0);
		for (int k = 0; k < 10; k++) begin
			apb(1, {8'h0, cs_sel[k], 2'b00}, {cs_code[k], cs_mask[k], 9'h0}, '0);
			apb(1, OFF_ROUTE, 32'h1 << cs_n[k], '0);
			apb(1, OFF_EDGE, (k == 9) ? 32'h100 : 32'h0, '0);
			apb(1, OFF_CNT_LO + 12'(4 * cs_n[k]), '0, '0);
			acc = 0;
			for (int i = 0; i < 40; i++) begin
				@(posedge pclk);
				r = $random(seed);
				kind = (i % 4 == 0 && r[7:6] != 2'h3) ? r[7:6] : 2'h0;
				case (k)
					0: acc += 32'(r[5:4]);
					1: acc += 32'(r[3:2]);
					2: acc += 32'(r[1]);
					3: acc += 32'(r[1]) + 32'(r[0]);
					4: acc += 32'(kind == 2'h1);
					5: acc += 32'(kind == 2'h2);
					// clear level stands two cycles per clear
					8: acc += 32'(kind != 2'h0) * 2;
					9: acc += 32'(kind != 2'h0);
					default: ;
				endcase
				go <= 1'b1;
				cmd <= r[5:0];
				clr_req <= kind;
			end
			@(posedge pclk);
			go <= 1'b0;
			repeat (3) @(posedge pclk);
			apb(0, OFF_CNT_LO + 12'(4 * cs_n[k]), '0, {1'b0, acc});
			apb(0, OFF_CNT_HI + 12'(4 * cs_n[k]), '0, '0);
			$display("test %0d done", k);
		end
		repeat (2) @(posedge pclk);
		cmp("irq", '0, {32'h0, irq});
		print_verdict;
	end
endmodule
